/* File: rtl/afoc_map.vh */
`ifndef AFOC_MAP_VH
`define AFOC_MAP_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define AFOC_OFS_CLKCFG 8'h10
`define AFOC_OFS_VALUE 8'h11
`define AFOC_OFS_FANCFG 8'h12
`define AFOC_OFS_TARGET 8'h13
`define AFOC_OFS_TOL 8'h14
`define AFOC_OFS_STOP 8'h15
`define AFOC_OFS_START 8'h16
`define AFOC_OFS_STOPTIME 8'h17
`define AFOC_OFS_OVTCFG 8'h18
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AFOC_RST_CLKCFG 8'h04
`define AFOC_RST_VALUE 8'hff
`define AFOC_RST_FANCFG 8'h00
`define AFOC_RST_TARGET 8'h00
`define AFOC_RST_TOL 8'h00
`define AFOC_RST_STOP 8'h01
`define AFOC_RST_START 8'h01
`define AFOC_RST_STOPTIME 8'h3c
`define AFOC_RST_OVTCFG 8'h43
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AFOC_CLK_SRC_BIT 7
`define AFOC_PRESCALE_MSB 6
`define AFOC_FAN_DC_BIT 0
`define AFOC_MODE_LSB 1
`define AFOC_MODE_MSB 2
`define AFOC_AUX_FLOOR_BIT 3
`define AFOC_PROCA_FLOOR_BIT 4
`define AFOC_CHAS_FLOOR_BIT 5
`define AFOC_PROCB_FLOOR_BIT 6
`define AFOC_OVT_INTMODE_BIT 4
`define AFOC_OVT_DIS_BIT 6
`define AFOC_TOL_MSB 3
// ----------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------
`define AFOC_MODE_MANUAL 2'b00
`define AFOC_MODE_TEMP 2'b01
`define AFOC_MODE_SPEED 2'b10
// ----------------------------------------------------------------
// Clock rates and times
// ----------------------------------------------------------------
`define AFOC_MCLK_KHZ 250000
`define AFOC_SRC_FAST_KHZ 24000
`define AFOC_SRC_SLOW_KHZ 180
`define AFOC_UNIT_PWM_MS 100
`define AFOC_UNIT_DC_MS 400
`define AFOC_PWM_STEPS 256
`endif

/* File: rtl/afoc_aux_fan_output_control.v */
// What this block does
// - Clock-select bit 0 picks 24 MHz, 1 picks 180 KHz source.
// - Source divided by seven-bit prescale, then 256 ticks per period.
// - Frequency settings matter only while output type is PWM.
// - PWM duty equals value over 256; FFh full high, 00h low.
// - DC output uses value bits 7..2 as level over 64.
// - Type bit 0 selects PWM waveform, 1 selects DC level.
// - Mode field: 00 manual, 01 temperature, 10 speed, 11 none.
// - Below target, aux output falls to zero, or to stop value.
// - Bits 4,5,6 give the same floor choice for three fans.
// - Target holds 7-bit temperature or 8-bit speed by mode.
// - Tolerance low nibble sets band around target.
// - Staying cold, output lowers until it reaches stop value.
// - Starting fan, output jumps from zero to start-up value.
// - Stop time counts 0.1 s units for PWM, 0.4 s for DC.
// - Over-temperature bit 6 low drives output, high suppresses it.
// - Over-temperature bit 4 selects compare or interrupt mode.
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "afoc_map.vh"
module afoc_aux_fan_output_control
#(
  parameter UNIT_PWM_CYC = `AFOC_UNIT_PWM_MS * `AFOC_MCLK_KHZ,
  parameter UNIT_DC_CYC = `AFOC_UNIT_DC_MS * `AFOC_MCLK_KHZ,
  parameter STEP_UNITS = 1
)
(
  input wire mclk,
  input wire rst_b,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  output reg [7:0] regRdData,
  input wire [7:0] auxTempInput,
  input wire [7:0] auxTachInput,
  input wire [7:0] chassisTempInput,
  input wire [7:0] chassisTempHigh,
  input wire [7:0] chassisTempHyst,
  output reg auxFanDrive,
  output reg [5:0] auxFanDcLevel,
  output reg auxFanDcMode,
  output wire procFanAFloor,
  output wire chassisFanFloor,
  output wire procFanBFloor,
  output reg overtempOut_n
);

// ----------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------
localparam [17:0] MCLK_K = `AFOC_MCLK_KHZ;
localparam [17:0] FAST_K = `AFOC_SRC_FAST_KHZ;
localparam [17:0] SLOW_K = `AFOC_SRC_SLOW_KHZ;
localparam [26:0] UNIT_PWM = UNIT_PWM_CYC;
localparam [26:0] UNIT_DC = UNIT_DC_CYC;
localparam [7:0] STEP_N = STEP_UNITS;

// Phase accumulator step: returns {pulse, next phase}
function [18:0] phaseNext;
  input [17:0] acc;
  input [17:0] inc;
  reg [18:0] sum;
  begin
    sum = {1'b0, acc} + {1'b0, inc};
    if (sum >= {1'b0, MCLK_K})
      phaseNext = {1'b1, sum[17:0] - MCLK_K};
    else
      phaseNext = {1'b0, sum[17:0]};
  end
endfunction

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg [7:0] clkCfg_q;
reg [7:0] value_q;
reg [7:0] fanCfg_q;
reg [7:0] target_q;
reg [7:0] tol_q;
reg [7:0] stop_q;
reg [7:0] start_q;
reg [7:0] stopTime_q;
reg [7:0] ovtCfg_q;
reg ovtState_q;
reg hotPrev_q;

wire wrValue;
wire [1:0] mode;
wire dcMode;
wire autoStep;
reg [7:0] valueNext;

assign wrValue = regWrEn && (regAddr == `AFOC_OFS_VALUE);
assign mode = fanCfg_q[`AFOC_MODE_MSB:`AFOC_MODE_LSB];
assign dcMode = fanCfg_q[`AFOC_FAN_DC_BIT];
assign procFanAFloor = fanCfg_q[`AFOC_PROCA_FLOOR_BIT];
assign chassisFanFloor = fanCfg_q[`AFOC_CHAS_FLOOR_BIT];
assign procFanBFloor = fanCfg_q[`AFOC_PROCB_FLOOR_BIT];

always @(posedge mclk or negedge rst_b)
begin
  if (!rst_b)
  begin
    clkCfg_q <= `AFOC_RST_CLKCFG;
    fanCfg_q <= `AFOC_RST_FANCFG;
    target_q <= `AFOC_RST_TARGET;
    tol_q <= `AFOC_RST_TOL;
    stop_q <= `AFOC_RST_STOP;
    start_q <= `AFOC_RST_START;
    stopTime_q <= `AFOC_RST_STOPTIME;
    ovtCfg_q <= `AFOC_RST_OVTCFG;
  end
  else if (regWrEn)
  begin
    case (regAddr)
      `AFOC_OFS_CLKCFG: clkCfg_q <= regWrData;
      `AFOC_OFS_FANCFG: fanCfg_q <= regWrData;
      `AFOC_OFS_TARGET: target_q <= regWrData;
      `AFOC_OFS_TOL: tol_q <= regWrData;
      `AFOC_OFS_STOP: stop_q <= regWrData;
      `AFOC_OFS_START: start_q <= regWrData;
      `AFOC_OFS_STOPTIME: stopTime_q <= regWrData;
      `AFOC_OFS_OVTCFG: ovtCfg_q <= regWrData;
      default: ;
    endcase
  end
end

// Read data one cycle after the strobe; unmapped reads zero
always @(posedge mclk or negedge rst_b)
begin
  if (!rst_b)
    regRdData <= 8'h00;
  else if (regRdEn)
  begin
    case (regAddr)
      `AFOC_OFS_CLKCFG: regRdData <= clkCfg_q;
      `AFOC_OFS_VALUE: regRdData <= value_q;
      `AFOC_OFS_FANCFG: regRdData <= fanCfg_q;
      `AFOC_OFS_TARGET: regRdData <= target_q;
      `AFOC_OFS_TOL: regRdData <= tol_q;
      `AFOC_OFS_STOP: regRdData <= stop_q;
      `AFOC_OFS_START: regRdData <= start_q;
      `AFOC_OFS_STOPTIME: regRdData <= stopTime_q;
      `AFOC_OFS_OVTCFG: regRdData <= {ovtCfg_q[7:1], ovtState_q};
      default: regRdData <= 8'h00;
    endcase
  end
  else
    regRdData <= 8'h00;
end

// ----------------------------------------------------------------
// Source clock enables
// ----------------------------------------------------------------
reg [17:0] fastAcc_q;
reg [17:0] slowAcc_q;
reg srcTick_q;
wire [18:0] fastNext;
wire [18:0] slowNext;

assign fastNext = phaseNext(fastAcc_q, FAST_K);
assign slowNext = phaseNext(slowAcc_q, SLOW_K);

always @(posedge mclk or negedge rst_b)
begin
  if (!rst_b)
  begin
    fastAcc_q <= 18'h00000;
    slowAcc_q <= 18'h00000;
    srcTick_q <= 1'b0;
  end
  else
  begin
    fastAcc_q <= fastNext[17:0];
    slowAcc_q <= slowNext[17:0];
    if (clkCfg_q[`AFOC_CLK_SRC_BIT])
      srcTick_q <= slowNext[18];
    else
      srcTick_q <= fastNext[18];
  end
end

// ----------------------------------------------------------------
// Prescaler and PWM period
// ----------------------------------------------------------------
reg [6:0] preCnt_q;
reg [7:0] slot_q;
reg [7:0] duty_q;
wire [6:0] preDiv;
wire preTick;

// Zero prescale is held as one so the period never freezes
assign preDiv = (clkCfg_q[`AFOC_PRESCALE_MSB:0] == 7'h00) ?
  7'h01 : clkCfg_q[`AFOC_PRESCALE_MSB:0];
assign preTick = srcTick_q && (preCnt_q == preDiv - 7'h01);

always @(posedge mclk or negedge rst_b)
begin
  if (!rst_b)
  begin
    preCnt_q <= 7'h00;
    slot_q <= 8'h00;
    duty_q <= `AFOC_RST_VALUE;
  end
  else if (srcTick_q)
  begin
    if (preTick)
    begin
      preCnt_q <= 7'h00;
      slot_q <= slot_q + 8'h01;
      if (slot_q == 8'hff)
        duty_q <= value_q;
    end
    else if (preCnt_q >= preDiv)
      preCnt_q <= 7'h00;
    else
      preCnt_q <= preCnt_q + 7'h01;
  end
end

// ----------------------------------------------------------------
// Pin drive
// ----------------------------------------------------------------
always @(posedge mclk or negedge rst_b)
begin
  if (!rst_b)
  begin
    auxFanDrive <= 1'b0;
    auxFanDcLevel <= 6'h00;
    auxFanDcMode <= 1'b0;
  end
  else
  begin
    auxFanDcMode <= dcMode;
    auxFanDcLevel <= dcMode ? value_q[7:2] : 6'h00;
    if (dcMode)
      auxFanDrive <= 1'b0;
    else
      auxFanDrive <= (duty_q == 8'hff) || (slot_q < duty_q);
  end
end

// ----------------------------------------------------------------
// Time unit and step ticks
// ----------------------------------------------------------------
reg [26:0] unitCnt_q;
reg [7:0] stepCnt_q;
reg [7:0] floorCnt_q;
wire unitTick;
wire [26:0] unitLen;

assign unitLen = dcMode ? UNIT_DC : UNIT_PWM;
assign unitTick = (unitCnt_q >= unitLen - 27'h1);
assign autoStep = unitTick && (stepCnt_q >= STEP_N - 8'h01);

always @(posedge mclk or negedge rst_b)
begin
  if (!rst_b)
  begin
    unitCnt_q <= 27'h0;
    stepCnt_q <= 8'h00;
  end
  else if (unitTick)
  begin
    unitCnt_q <= 27'h0;
    stepCnt_q <= autoStep ? 8'h00 : stepCnt_q + 8'h01;
  end
  else
    unitCnt_q <= unitCnt_q + 27'h1;
end

// ----------------------------------------------------------------
// Automatic control
// ----------------------------------------------------------------
wire [8:0] tgtTemp;
wire [8:0] tgtSpeed;
wire [8:0] band;
wire [8:0] tempV;
wire [8:0] tachV;
wire tooHot;
wire tooCold;
wire tooSlow;
wire tooFast;
wire holdFloor;

assign band = {5'h00, tol_q[`AFOC_TOL_MSB:0]};
assign tgtTemp = {2'b00, target_q[6:0]};
assign tgtSpeed = {1'b0, target_q};
assign tempV = {1'b0, auxTempInput};
assign tachV = {1'b0, auxTachInput};
assign tooHot = tempV > tgtTemp + band;
assign tooCold = tempV + band < tgtTemp;
// Tach gives counts per turn: larger count means slower
assign tooSlow = tachV > tgtSpeed + band;
assign tooFast = tachV + band < tgtSpeed;
assign holdFloor = fanCfg_q[`AFOC_AUX_FLOOR_BIT];

always @*
begin
  valueNext = value_q;
  case (mode)
    `AFOC_MODE_TEMP:
    begin
      if (tooHot)
      begin
        if (value_q == 8'h00)
          valueNext = start_q;
        else if (value_q != 8'hff)
          valueNext = value_q + 8'h01;
      end
      else if (tooCold)
      begin
        if (value_q > stop_q)
          valueNext = value_q - 8'h01;
        else if (!holdFloor && (floorCnt_q >= stopTime_q))
          valueNext = 8'h00;
      end
    end
    `AFOC_MODE_SPEED:
    begin
      if (tooSlow && (value_q != 8'hff))
        valueNext = value_q + 8'h01;
      else if (tooFast && (value_q > stop_q))
        valueNext = value_q - 8'h01;
    end
    default: valueNext = value_q;
  endcase
end

// Software write wins over a hardware step in the same cycle
always @(posedge mclk or negedge rst_b)
begin
  if (!rst_b)
  begin
    value_q <= `AFOC_RST_VALUE;
    floorCnt_q <= 8'h00;
  end
  else
  begin
    if (wrValue)
      value_q <= regWrData;
    else if (autoStep)
      value_q <= valueNext;
    if ((mode != `AFOC_MODE_TEMP) || !tooCold || (value_q > stop_q)
        || (value_q == 8'h00))
      floorCnt_q <= 8'h00;
    else if (unitTick && (floorCnt_q != 8'hff))
      floorCnt_q <= floorCnt_q + 8'h01;
  end
end

// ----------------------------------------------------------------
// Over-temperature output
// ----------------------------------------------------------------
wire hot;
wire cool;
wire ovtClr;

assign hot = chassisTempInput >= chassisTempHigh;
assign cool = chassisTempInput < chassisTempHyst;
assign ovtClr = regRdEn && (regAddr == `AFOC_OFS_OVTCFG);

always @(posedge mclk or negedge rst_b)
begin
  if (!rst_b)
  begin
    ovtState_q <= 1'b0;
    hotPrev_q <= 1'b0;
    overtempOut_n <= 1'b1;
  end
  else
  begin
    hotPrev_q <= hot;
    if (ovtCfg_q[`AFOC_OVT_INTMODE_BIT])
    begin
      if (hot && !hotPrev_q)
        ovtState_q <= 1'b1;
      else if (ovtClr)
        ovtState_q <= 1'b0;
    end
    else if (hot)
      ovtState_q <= 1'b1;
    else if (cool)
      ovtState_q <= 1'b0;
    overtempOut_n <= !(ovtState_q &&
      !ovtCfg_q[`AFOC_OVT_DIS_BIT]);
  end
end

endmodule
`default_nettype wire

/* File: bench/afoc_aux_fan_output_control_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module afoc_aux_fan_output_control_monitor (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] chassisTempInput,
  input wire logic [7:0] chassisTempHigh,
  input wire logic [7:0] chassisTempHyst,
  input wire logic auxFanDrive,
  input wire logic [5:0] auxFanDcLevel,
  input wire logic auxFanDcMode,
  input wire logic procFanAFloor,
  input wire logic chassisFanFloor,
  input wire logic procFanBFloor,
  input wire logic overtempOut_n
);
  // ------------------------------------------------------------
  // Shadow of over-temperature config
  // ------------------------------------------------------------
  logic ovtDis_q;
  logic ovtInt_q;
  wire wr12 = regWrEn && regAddr == 8'h12;
  wire wr18 = regWrEn && regAddr == 8'h18;
  wire acc18 = (regWrEn || regRdEn) && regAddr == 8'h18;
  wire live = ovtInt_q && !ovtDis_q;
  wire hot = chassisTempInput >= chassisTempHigh;
  wire cool = chassisTempInput < chassisTempHyst;
  always @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      ovtDis_q <= 1'b1;
      ovtInt_q <= 1'b0;
    end
    else if (wr18)
    begin
      ovtDis_q <= regWrData[6];
      ovtInt_q <= regWrData[4];
    end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  dc_mode_a: assert property (wr12 |-> ##2
    auxFanDcMode == $past(regWrData[0], 2))
    else $error("dc mode bit not taken");
  floor_bits_a: assert property (wr12 |=>
    {procFanBFloor, chassisFanFloor, procFanAFloor} == $past(regWrData[6:4]))
    else $error("floor bits wrong");
  dc_pin_low_a: assert property (auxFanDcMode &&
    $past(auxFanDcMode) |-> !auxFanDrive)
    else $error("pwm pin active in dc mode");
  pwm_lvl_zero_a: assert property (!auxFanDcMode &&
    $past(!auxFanDcMode) |-> auxFanDcLevel == 6'h00)
    else $error("dc level in pwm mode");
  ovt_off_a: assert property (ovtDis_q &&
    $past(ovtDis_q) |-> overtempOut_n)
    else $error("suppressed output asserted");
  cmp_set_a: assert property ((!ovtDis_q && !ovtInt_q && hot)[*3]
    |-> !overtempOut_n) else $error("compare set missing");
  cmp_clr_a: assert property ((!ovtDis_q && !ovtInt_q && cool)[*3]
    |-> overtempOut_n) else $error("compare clear missing");
  int_hold_a: assert property (live && !acc18 ##1
    live && !overtempOut_n && !acc18 ##1 live |=> !overtempOut_n)
    else $error("latch dropped");
  cover property (wr12 ##1 auxFanDcMode);
  cover property (live && !overtempOut_n);
  cover property (!ovtInt_q && !ovtDis_q && !overtempOut_n);
endmodule
bind afoc_aux_fan_output_control afoc_aux_fan_output_control_monitor mon (
  .mclk, .rst_b, .regAddr, .regWrData, .regWrEn, .regRdEn,
  .chassisTempInput, .chassisTempHigh, .chassisTempHyst, .auxFanDrive,
  .auxFanDcLevel, .auxFanDcMode, .procFanAFloor, .chassisFanFloor,
  .procFanBFloor, .overtempOut_n);
`default_nettype wire

/* File: bench/afoc_fan_model.sv */
`timescale 1ns/10ps
`default_nettype none
module afoc_fan_model (
  input wire logic mclk,
  input wire logic drive,
  input wire logic dcMode,
  input wire logic [5:0] dcLevel,
  output logic [7:0] tach
);
  // ------------------------------------------------------------
  // Tach count falls as average drive rises
  // ------------------------------------------------------------
  logic [7:0] cnt_q = 8'h00;
  logic [7:0] hi_q = 8'h00;
  initial
  begin
    tach = 8'hff;
  end
  always @(posedge mclk)
  begin
    cnt_q <= cnt_q + 8'h01;
    hi_q <= (cnt_q == 8'hff) ? 8'h00 : hi_q + {7'h00, drive};
    if (cnt_q == 8'hff)
      tach <= dcMode ? ~{dcLevel, 2'b00} : ~hi_q;
  end
endmodule
`default_nettype wire

/* File: bench/afoc_aux_fan_output_control_test.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) \
  begin \
    check_count++; \
    if ((e) !== (s)) \
    begin \
      mismatches++; \
      $display("Error %s exp %h seen %h", n, e, s); \
    end \
  end
module afoc_aux_fan_output_control_test;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic rdLag = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] auxTemp = 8'h00;
  logic [7:0] chasTemp = 8'h00;
  logic [7:0] regRdData, tach, lastRd, d;
  logic auxFanDrive, auxFanDcMode, overtempOut_n;
  logic [5:0] dcLevel;
  logic [8:0] expQ[$];
  logic [8:0] e;
  int mismatches = 0;
  int check_count = 0;
  int n;
  logic [7:0] rv[9] = '{8'h04, 8'hff, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01,
    8'h3c, 8'h42};
  afoc_aux_fan_output_control #(.UNIT_PWM_CYC(20), .UNIT_DC_CYC(80),
    .STEP_UNITS(16)) dut (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .auxTempInput(auxTemp), .auxTachInput(tach),
    .chassisTempInput(chasTemp), .chassisTempHigh(8'h50),
    .chassisTempHyst(8'h46), .auxFanDrive(auxFanDrive),
    .auxFanDcLevel(dcLevel), .auxFanDcMode(auxFanDcMode),
    .procFanAFloor(), .chassisFanFloor(), .procFanBFloor(),
    .overtempOut_n(overtempOut_n));
  afoc_fan_model fan (.mclk(mclk), .drive(auxFanDrive),
    .dcMode(auxFanDcMode), .dcLevel(dcLevel), .tach(tach));
  // ------------------------------------------------------------
  // Bus tasks and read watcher
  // ------------------------------------------------------------
  task wr(input [7:0] a, input [7:0] v);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= v;
    regWrEn <= 1'b1;
    @(posedge mclk);
    regWrEn <= 1'b0;
  endtask
  task rd(input [7:0] a, input [8:0] ev);
    @(posedge mclk);
    regAddr <= a;
    regRdEn <= 1'b1;
    expQ.push_back(ev);
    @(posedge mclk);
    regRdEn <= 1'b0;
    @(negedge mclk);
    lastRd = regRdData;
  endtask
  always @(posedge mclk) rdLag <= regRdEn;
  always @(negedge mclk)
    if (rdLag)
    begin
      e = expQ.pop_front();
      if (e[8]) `CHK("read", e[7:0], regRdData)
    end
  task tick(input int c);
    repeat (c) @(posedge mclk);
    @(negedge mclk);
  endtask
  task duty(input [7:0] v);
    int hi, ex;
    logic ok;
    hi = 0;
    ex = 8000 * v / 256;
    wr(8'h11, v);
    repeat (2700) @(posedge mclk);
    repeat (8000) @(posedge mclk) hi += auxFanDrive;
    ok = (v == 8'h00) ? (hi == 0) : (v == 8'hff) ? (hi == 8000) :
      (hi >= ex - 8 && hi <= ex + 8);
    `CHK("duty", 1'b1, ok)
  endtask
  task rise(input int lim, output int c);
    logic p;
    c = 0;
    p = auxFanDrive;
    while (c < lim && !(auxFanDrive && !p))
    begin
      p = auxFanDrive;
      @(posedge mclk);
      c++;
    end
  endtask
  task ovt(input [7:0] t, input x);
    @(posedge mclk);
    chasTemp <= t;
    tick(4);
    `CHK("ovt", x, overtempOut_n)
  endtask
  task test_done;
    if (mismatches == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    #380000;
    mismatches++;
    test_done;
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(66345));
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    for (int i = 0; i < 9; i++)
      rd(8'h10 + i, {1'b1, rv[i]});
    rd(8'h19, 9'h100);
    rd(8'h0f, 9'h100);
    for (int a = 8'h13; a < 8'h18; a++)
    begin
      d = $urandom;
      d[0] = d[0] | (a == 8'h15);
      wr(a[7:0], d);
      rd(a[7:0], {1'b1, d});
    end
    wr(8'h10, 8'h01);
    duty(8'h00);
    duty(8'hff);
    duty($urandom_range(8'hfe, 8'h01));
    wr(8'h10, 8'h03);
    wr(8'h11, 8'h80);
    rise(20000, n);
    rise(20000, n);
    `CHK("period", 1'b1, n >= 7998 && n <= 8002)
    wr(8'h10, 8'h81);
    rise(6000, n);
    `CHK("slow src", 6000, n)
    wr(8'h11, 8'h00);
    wr(8'h15, 8'h10);
    wr(8'h16, 8'h30);
    wr(8'h13, 8'ha8);
    wr(8'h14, 8'h02);
    @(posedge mclk);
    auxTemp <= 8'h3c;
    wr(8'h12, 8'h0a);
    n = 0;
    lastRd = 8'h00;
    while (lastRd == 8'h00 && n < 200)
    begin
      rd(8'h11, 9'h000);
      n++;
    end
    `CHK("start", 8'h30, lastRd)
    @(posedge mclk);
    auxTemp <= 8'h14;
    tick(12000);
    rd(8'h11, 9'h110);
    wr(8'h17, 8'h03);
    wr(8'h12, 8'h02);
    tick(1000);
    rd(8'h11, 9'h100);
    wr(8'h12, 8'h00);
    wr(8'h11, 8'h78);
    wr(8'h13, 8'h80);
    wr(8'h14, 8'h04);
    // Speed loop in DC output, where the tach takes the level once every 256 clocks
    wr(8'h12, 8'h05);
    tick(9000);
    `CHK("speed", 1'b1, tach >= 8'h7a && tach <= 8'h86)
    wr(8'h12, 8'h06);
    wr(8'h11, 8'h55);
    tick(1000);
    rd(8'h11, 9'h155);
    wr(8'h12, 8'h01);
    repeat (3)
    begin
      d = $urandom;
      wr(8'h11, d);
      wr(8'h10, 8'h7f);
      tick(3);
      `CHK("dc level", d[7:2], dcLevel)
    end
    wr(8'h18, 8'h00);
    ovt(8'h5a, 1'b0);
    ovt(8'h4b, 1'b0);
    ovt(8'h3c, 1'b1);
    wr(8'h18, 8'h10);
    ovt(8'h5a, 1'b0);
    ovt(8'h3c, 1'b0);
    rd(8'h18, 9'h111);
    tick(4);
    `CHK("ovt clr", 1'b1, overtempOut_n)
    wr(8'h18, 8'h50);
    ovt(8'h5a, 1'b1);
    test_done;
  end
endmodule
`default_nettype wire
